// ### verilog/esf_pkg.sv
// Package of constants, types and the register map for the edge sharpening filter.
package esf_pkg;

    // Pixel and line geometry.
    localparam int          PIX_W      = 8;
    localparam int          COL_W      = 10;
    localparam int          LINE_MAX   = 1024;

    // Register port widths.
    localparam int          ADDR_W     = 8;
    localparam int          DATA_W     = 32;

    // Register byte offsets.
    localparam logic [7:0]  OFS_CTRL      = 8'h00;
    localparam logic [7:0]  OFS_THRESH    = 8'h04;
    localparam logic [7:0]  OFS_AMOUNT    = 8'h08;
    localparam logic [7:0]  OFS_AUTO_GAIN = 8'h0C;
    localparam logic [7:0]  OFS_ACT_THR   = 8'h10;
    localparam logic [7:0]  OFS_NOISE     = 8'h14;
    localparam logic [7:0]  OFS_STATUS    = 8'h18;
    localparam logic [7:0]  OFS_EDGE_CNT  = 8'h1C;
    localparam logic [7:0]  OFS_FRAME_CNT = 8'h20;
    localparam logic [7:0]  OFS_LINE_LEN  = 8'h24;

    // Control field positions.
    localparam int          CTRL_EN_BIT   = 0;
    localparam int          CTRL_AUTO_BIT = 1;

    // Values after reset.
    localparam logic [1:0]  RST_CTRL      = 2'h0;
    localparam logic [15:0] RST_THRESH    = 16'h0800;
    localparam logic [15:0] RST_AMOUNT    = 16'h0200;
    localparam logic [7:0]  RST_AUTO_GAIN = 8'h30;

    // Threshold is a 0.16 fraction of full range; one quarter is the ceiling.
    localparam logic [15:0] THR_MAX       = 16'h4000;
    localparam logic [11:0] THR_MAX_PIX   = 12'h040;

    // Amount is signed 8.8; boost stops at 8.0 and smoothing at -1.0.
    localparam logic [15:0] AMT_MAX       = 16'h0800;
    localparam logic [15:0] AMT_MIN       = 16'hFF00;

    // Cycles from a pixel at the input to the same pixel at the output.
    localparam int          LAT_CYCLES    = 2;

    typedef struct packed {
        logic             valid;
        logic             sof;
        logic             eol;
        logic [PIX_W-1:0] data;
    } esf_pix_s;

    typedef enum logic [1:0] {
        LN_FIRST = 2'b01,
        LN_REST  = 2'b10
    } esf_line_e;

endpackage : esf_pkg

// ### verilog/esf_line_mem.sv
// One-line pixel memory with registered read data.
`timescale 1ns/10ps
module esf_line_mem
    import esf_pkg::*;
(
    // Clock.
    input  wire logic             clock,
    // Write side.
    input  wire logic             wr_en,
    input  wire logic [COL_W-1:0] wr_addr,
    input  wire logic [PIX_W-1:0] wr_data,
    // Read side.
    input  wire logic [COL_W-1:0] rd_addr,
    output logic      [PIX_W-1:0] rd_data
);

    logic [PIX_W-1:0] mem [LINE_MAX];

    // Read returns the old word when the same column is written.
    always_ff @(posedge clock) begin
        rd_data <= mem[rd_addr];
    end

    always_ff @(posedge clock) begin
        if (wr_en) begin
            mem[wr_addr] <= wr_data;
        end
    end

endmodule : esf_line_mem

// ### verilog/esf_rst_sync.sv
// Reset synchroniser: asynchronous assert, release through two flip-flops.
`timescale 1ns/10ps
module esf_rst_sync (
    // Clock and raw reset.
    input  wire logic clock,
    input  wire logic rst_n,
    // Released reset.
    output logic      rst_sync_n
);

    logic stage_q;

    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            stage_q    <= 1'b0;
            rst_sync_n <= 1'b0;
        end else begin
            stage_q    <= 1'b1;
            rst_sync_n <= stage_q;
        end
    end

endmodule : esf_rst_sync

// ### verilog/esf_filter.sv
// Edge sharpening filter: register port, causal neighbourhood and correction.
//
// Contract
// - Sharpening comes out of reset switched off.
// - Off passes pixels untouched; on lets amount and threshold govern output.
// - Only pixels whose gradient exceeds the active threshold are changed.
// - Threshold is a fraction of full range, from 0 to one quarter.
// - Thresholds above one quarter act as exactly one quarter.
// - Manual mode uses the software threshold as the gradient that must be exceeded.
// - Auto mode derives the threshold from the measured noise level.
// - Amount zero leaves pixels, negative smooths, positive boosts edges.
// - Correction is the pixel minus the mean of its left and upper neighbours, scaled by the amount.
// - Boost is limited to eight times, smoothing to one times the difference.
// - Amount resets to 2.0.
`timescale 1ns/10ps
module esf_filter
    import esf_pkg::*;
(
    // Clock and reset.
    input  wire logic              clock,
    input  wire logic              rst_n,
    // Register port.
    input  wire logic [ADDR_W-1:0] reg_addr,
    input  wire logic [DATA_W-1:0] reg_wdata,
    input  wire logic              reg_we,
    input  wire logic              reg_re,
    output logic      [DATA_W-1:0] reg_rdata,
    // Noise estimate from the pipeline.
    input  wire logic [PIX_W-1:0]  noise_level,
    // Pixel stream.
    input  wire esf_pix_s          pix_in,
    output esf_pix_s               pix_out
);

    logic              rst_sync_n;

    // Settings.
    logic              enable_q;
    logic              auto_q;
    logic [15:0]       thresh_q;
    logic [15:0]       amount_q;
    logic [7:0]        auto_gain_q;

    // Derived settings.
    logic [11:0]       thr_act_d;
    logic [11:0]       thr_act_q;
    logic [15:0]       amt_eff_d;
    logic [15:0]       amt_eff_q;

    // Stream position.
    esf_line_e         line_q;
    logic [COL_W-1:0]  col_q;
    logic [COL_W-1:0]  rd_col;
    logic [COL_W:0]    line_len_q;
    logic              up_ok_q;
    logic              left_ok_q;
    logic [PIX_W-1:0]  left_q;
    logic [PIX_W-1:0]  above;
    esf_pix_s          in_q;

    // Statistics.
    logic [31:0]       edge_run_q;
    logic [31:0]       edge_cnt_q;
    logic [31:0]       frame_cnt_q;

    // Kernel signals.
    logic [PIX_W-1:0]  p_c;
    logic [PIX_W-1:0]  left_c;
    logic [PIX_W-1:0]  up_c;
    logic [PIX_W-1:0]  dl_c;
    logic [PIX_W-1:0]  du_c;
    logic [PIX_W-1:0]  grad_c;
    logic [8:0]        avg_sum_c;
    logic signed [9:0]  diff_c;
    logic signed [25:0] prod_c;
    logic signed [17:0] corr_c;
    logic signed [17:0] sum_c;
    logic [PIX_W-1:0]  sat_c;
    logic              edge_c;
    logic [PIX_W-1:0]  out_data_c;
    logic [15:0]       thr_man_c;
    logic [15:0]       auto_prod_c;

    // Everything below leaves reset two edges after the pin rises, so the bus
    // and the stream must stay quiet until the third edge.
    esf_rst_sync u_rst_sync (
        .clock      (clock),
        .rst_n      (rst_n),
        .rst_sync_n (rst_sync_n)
    );

    // Control register.
    // Enable resets off.
    always_ff @(posedge clock or negedge rst_sync_n) begin
        if (!rst_sync_n) begin
            enable_q <= RST_CTRL[CTRL_EN_BIT];
            auto_q   <= RST_CTRL[CTRL_AUTO_BIT];
        end else if (reg_we && reg_addr == OFS_CTRL) begin
            enable_q <= reg_wdata[CTRL_EN_BIT];
            auto_q   <= reg_wdata[CTRL_AUTO_BIT];
        end
    end

    // Threshold register keeps the value as written.
    // The clamp sits downstream so software always reads back its own value.
    always_ff @(posedge clock or negedge rst_sync_n) begin
        if (!rst_sync_n) begin
            thresh_q <= RST_THRESH;
        end else if (reg_we && reg_addr == OFS_THRESH) begin
            thresh_q <= reg_wdata[15:0];
        end
    end

    // Amount register keeps the raw signed 8.8 value.
    // Amount resets to 2.0.
    always_ff @(posedge clock or negedge rst_sync_n) begin
        if (!rst_sync_n) begin
            amount_q <= RST_AMOUNT;
        end else if (reg_we && reg_addr == OFS_AMOUNT) begin
            amount_q <= reg_wdata[15:0];
        end
    end

    // Noise-to-threshold gain in unsigned 4.4.
    always_ff @(posedge clock or negedge rst_sync_n) begin
        if (!rst_sync_n) begin
            auto_gain_q <= RST_AUTO_GAIN;
        end else if (reg_we && reg_addr == OFS_AUTO_GAIN) begin
            auto_gain_q <= reg_wdata[7:0];
        end
    end

    // Active threshold in pixel units.
    // Clamping before the fraction bits are dropped keeps huge writes from wrapping.
    // The noise path is clamped the same way, so both modes share one ceiling.
    always_comb begin
        auto_prod_c = noise_level * auto_gain_q;
        thr_man_c   = (thresh_q > THR_MAX) ? THR_MAX : thresh_q;
        if (auto_q) begin
            if (auto_prod_c[15:4] > THR_MAX_PIX) begin
                thr_act_d = THR_MAX_PIX;
            end else begin
                thr_act_d = auto_prod_c[15:4];
            end
        end else begin
            thr_act_d = {4'h0, thr_man_c[15:8]};
        end
    end

    // Effective amount, clamped to the allowed range.
    // Clamping once here bounds the multiplier input, so no later stage can overflow.
    always_comb begin
        if ($signed(amount_q) > $signed(AMT_MAX)) begin
            amt_eff_d = AMT_MAX;
        end else if ($signed(amount_q) < $signed(AMT_MIN)) begin
            amt_eff_d = AMT_MIN;
        end else begin
            amt_eff_d = amount_q;
        end
    end

    // Derived settings are registered to keep the multiplier off the bus path;
    // a settings change therefore reaches pixels one cycle after the write.
    always_ff @(posedge clock or negedge rst_sync_n) begin
        if (!rst_sync_n) begin
            thr_act_q <= 12'h000;
            amt_eff_q <= RST_AMOUNT;
        end else begin
            thr_act_q <= thr_act_d;
            amt_eff_q <= amt_eff_d;
        end
    end

    // Read data stand for one cycle after the read strobe.
    // Clearing the data outside the read slot keeps stale values off the bus.
    always_ff @(posedge clock or negedge rst_sync_n) begin
        if (!rst_sync_n) begin
            reg_rdata <= 32'h0000_0000;
        end else if (reg_re) begin
            case (reg_addr)
                OFS_CTRL:      reg_rdata <= {30'h0000_0000, auto_q, enable_q};
                OFS_THRESH:    reg_rdata <= {16'h0000, thresh_q};
                OFS_AMOUNT:    reg_rdata <= {16'h0000, amount_q};
                OFS_AUTO_GAIN: reg_rdata <= {24'h00_0000, auto_gain_q};
                OFS_ACT_THR:   reg_rdata <= {20'h0_0000, thr_act_q};
                OFS_NOISE:     reg_rdata <= {24'h00_0000, noise_level};
                OFS_STATUS:    reg_rdata <= {30'h0000_0000, line_q};
                OFS_EDGE_CNT:  reg_rdata <= edge_cnt_q;
                OFS_FRAME_CNT: reg_rdata <= frame_cnt_q;
                OFS_LINE_LEN:  reg_rdata <= {21'h00_0000, line_len_q};
                default:       reg_rdata <= 32'h0000_0000;
            endcase
        end else begin
            reg_rdata <= 32'h0000_0000;
        end
    end

    // Line tracking: the first line of a frame has no line above it.
    // A one-pixel line carries both flags and moves straight to the later lines.
    // Raster position.
    always_ff @(posedge clock or negedge rst_sync_n) begin
        if (!rst_sync_n) begin
            line_q <= LN_FIRST;
        end else if (pix_in.valid) begin
            case (line_q)
                LN_FIRST: begin
                    if (pix_in.eol) begin
                        line_q <= LN_REST;
                    end
                end
                LN_REST: begin
                    if (pix_in.sof && pix_in.eol) begin
                        line_q <= LN_REST;
                    end else if (pix_in.sof) begin
                        line_q <= LN_FIRST;
                    end
                end
                default: line_q <= LN_FIRST;
            endcase
        end
    end

    // A frame start forces column zero, so a short or broken last line cannot
    // shift the line buffer addresses of the next frame.
    assign rd_col = pix_in.sof ? {COL_W{1'b0}} : col_q;

    // Column counter restarts at each line end and frame start.
    always_ff @(posedge clock or negedge rst_sync_n) begin
        if (!rst_sync_n) begin
            col_q      <= {COL_W{1'b0}};
            line_len_q <= {(COL_W+1){1'b0}};
        end else if (pix_in.valid) begin
            if (pix_in.eol) begin
                col_q      <= {COL_W{1'b0}};
                line_len_q <= {1'b0, rd_col} + 11'h001;
            end else begin
                col_q <= rd_col + 10'h001;
            end
        end
    end

    // Read and write share one column; the old word read back is the pixel above.
    // Preceding line buffer.
    esf_line_mem u_line_mem (
        .clock   (clock),
        .wr_en   (pix_in.valid),
        .wr_addr (rd_col),
        .wr_data (pix_in.data),
        .rd_addr (rd_col),
        .rd_data (above)
    );

    // Input register, aligned with the line buffer read data.
    // The first line and every frame start have no valid pixel above.
    always_ff @(posedge clock or negedge rst_sync_n) begin
        if (!rst_sync_n) begin
            in_q    <= '0;
            up_ok_q <= 1'b0;
        end else begin
            in_q    <= pix_in;
            up_ok_q <= !pix_in.sof && (line_q == LN_REST);
        end
    end

    // Left neighbour within the current line.
    // A line end clears the flag, so a new line never borrows the last pixel.
    always_ff @(posedge clock or negedge rst_sync_n) begin
        if (!rst_sync_n) begin
            left_q    <= 8'h00;
            left_ok_q <= 1'b0;
        end else if (in_q.valid) begin
            left_q    <= in_q.data;
            left_ok_q <= !in_q.eol;
        end
    end

    // Kernel: gradient test and scaled correction.
    // Only left and above exist in this causal window, so no pixel waits for a later line.
    // The sum saturates instead of wrapping, so a strong boost never folds an edge to black.
    always_comb begin
        p_c    = in_q.data;
        left_c = (left_ok_q && !in_q.sof) ? left_q : p_c;
        up_c   = up_ok_q ? above : p_c;
        dl_c   = (p_c >= left_c) ? (p_c - left_c) : (left_c - p_c);
        du_c   = (p_c >= up_c) ? (p_c - up_c) : (up_c - p_c);
        grad_c = (dl_c > du_c) ? dl_c : du_c;
        edge_c = ({4'h0, grad_c} > thr_act_q);
        avg_sum_c = {1'b0, left_c} + {1'b0, up_c};
        diff_c = $signed({2'b00, p_c}) - $signed({2'b00, avg_sum_c[8:1]});
        prod_c = diff_c * $signed(amt_eff_q);
        corr_c = prod_c[25:8];
        sum_c  = $signed({10'h000, p_c}) + corr_c;
        if (sum_c < 18'sh00000) begin
            sat_c = 8'h00;
        end else if (sum_c > 18'sh000FF) begin
            sat_c = 8'hFF;
        end else begin
            sat_c = sum_c[7:0];
        end
        out_data_c = (enable_q && edge_c) ? sat_c : p_c;
    end

    // Output register carries the stream flags with the same delay.
    // Flags bypass the kernel, so the frame timing downstream is untouched.
    // Timing preserved.
    always_ff @(posedge clock or negedge rst_sync_n) begin
        if (!rst_sync_n) begin
            pix_out <= '0;
        end else begin
            pix_out.valid <= in_q.valid;
            pix_out.sof   <= in_q.sof;
            pix_out.eol   <= in_q.eol;
            pix_out.data  <= out_data_c;
        end
    end

    // Per-frame count of changed pixels, latched at the next frame start.
    // A change on the frame start pixel seeds the count of the new frame.
    always_ff @(posedge clock or negedge rst_sync_n) begin
        if (!rst_sync_n) begin
            edge_run_q  <= 32'h0000_0000;
            edge_cnt_q  <= 32'h0000_0000;
            frame_cnt_q <= 32'h0000_0000;
        end else if (in_q.valid) begin
            if (in_q.sof) begin
                edge_cnt_q  <= edge_run_q;
                frame_cnt_q <= frame_cnt_q + 32'h0000_0001;
                edge_run_q  <= {31'h0000_0000, out_data_c != p_c};
            end else if (out_data_c != p_c) begin
                edge_run_q <= edge_run_q + 32'h0000_0001;
            end
        end
    end

endmodule : esf_filter

// ### bench/esf_filter_properties.sv
// Concurrent checks of the edge sharpening filter at its top ports.
`timescale 1ns/10ps
module esf_filter_properties
    import esf_pkg::*;
(
    // Clock and reset.
    input  wire logic              clock,
    input  wire logic              rst_n,
    // Register port.
    input  wire logic [ADDR_W-1:0] reg_addr,
    input  wire logic [DATA_W-1:0] reg_wdata,
    input  wire logic              reg_we,
    input  wire logic              reg_re,
    input  wire logic [DATA_W-1:0] reg_rdata,
    // Noise and pixels.
    input  wire logic [PIX_W-1:0]  noise_level,
    input  wire esf_pix_s          pix_in,
    input  wire esf_pix_s          pix_out
);
    logic [1:0]  ctrl_q;
    logic [15:0] amt_q;
    logic [3:0]  pass_q;

    // Shadow settings; pass_q records recent cycles in which no pixel may change.
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            ctrl_q <= RST_CTRL;
            amt_q  <= RST_AMOUNT;
            pass_q <= 4'hF;
        end else begin
            if (reg_we && reg_addr == OFS_CTRL) begin
                ctrl_q <= reg_wdata[1:0];
            end
            if (reg_we && reg_addr == OFS_AMOUNT) begin
                amt_q <= reg_wdata[15:0];
            end
            pass_q <= {pass_q[2:0], !ctrl_q[0] || amt_q == 16'h0000};
        end
    end

    default clocking cb @(posedge clock);
    endclocking
    default disable iff (!rst_n);

    sequence rd_s(logic [7:0] a);
        reg_re && reg_addr == a;
    endsequence

    latency_a: assert property (pix_out.valid == $past(pix_in.valid, 2))
        else $error("pixel valid not two cycles after input");
    flags_copy_a: assert property (pix_out.valid |->
        pix_out.sof == $past(pix_in.sof, 2) && pix_out.eol == $past(pix_in.eol, 2))
        else $error("frame flags not copied");
    bypass_a: assert property (pix_out.valid && pass_q == 4'hF && !ctrl_q[0] ||
        pix_out.valid && pass_q == 4'hF |-> pix_out.data == $past(pix_in.data, 2))
        else $error("pixel changed while bypassed");
    first_pix_a: assert property (pix_out.valid && pix_out.sof |->
        pix_out.data == $past(pix_in.data, 2))
        else $error("flat first pixel changed");
    rdata_idle_a: assert property (!$past(reg_re) |-> reg_rdata == 32'h00000000)
        else $error("read data outside read slot");
    ctrl_read_a: assert property (rd_s(OFS_CTRL) |=> reg_rdata == {30'h0, ctrl_q})
        else $error("control read wrong");
    amount_read_a: assert property (rd_s(OFS_AMOUNT) |=> reg_rdata == {16'h0, amt_q})
        else $error("amount read wrong");
    thr_cap_a: assert property (rd_s(OFS_ACT_THR) |=> reg_rdata <= {20'h0, THR_MAX_PIX})
        else $error("active threshold above quarter range");
    unmapped_a: assert property (reg_re && reg_addr >= 8'h28 |=> reg_rdata == 32'h00000000)
        else $error("unmapped read not zero");
endmodule : esf_filter_properties

// ### bench/esf_pix_src.sv
// Upstream pixel source model feeding the edge sharpening filter.
`timescale 1ns/10ps
module esf_pix_src
    import esf_pkg::*;
(
    // Clock.
    input  wire logic clock,
    // Pixel stream toward the filter.
    output esf_pix_s  pix
);
    initial pix = '0;

    // One pixel for one cycle; idle data is inverted so stale values never look valid.
    task automatic send(input logic [7:0] d, input logic s, input logic e);
        @(posedge clock);
        pix <= '{1'b1, s, e, d};
        @(posedge clock);
        pix <= '{1'b0, 1'b0, 1'b0, ~d};
    endtask : send
endmodule : esf_pix_src

// ### bench/tb_edge_sharpening_filter.sv
// Self-checking testbench of the edge sharpening filter.
`timescale 1ns/10ps
`define CHK(nm, exp, got) begin \
    cmp_count++; \
    if ((got) !== (exp)) begin \
        n_errors++; \
        $display("MISMATCH %s expected %0h seen %0h", nm, exp, got); \
    end \
end
module tb_edge_sharpening_filter
    import esf_pkg::*;
;
    typedef struct packed {
        logic [1:0]      ctrl;
        logic [15:0]     thr;
        logic [15:0]     amt;
        logic [7:0]      noise;
        logic [3:0][7:0] px;
        logic [3:0][7:0] want;
    } esf_row_s;
    logic              clock;
    logic              rst_n;
    logic [ADDR_W-1:0] reg_addr;
    logic [DATA_W-1:0] reg_wdata;
    logic              reg_we;
    logic              reg_re;
    logic [DATA_W-1:0] reg_rdata;
    logic [PIX_W-1:0]  noise_level;
    esf_pix_s          pix_in;
    esf_pix_s          pix_out;
    logic [7:0]        outq[$];
    int                n_errors;
    int                cmp_count;
    // Each row is one 2x2 frame: settings, pixels top-left first, expected pixels.
    esf_row_s          rows[12] = '{
        '{2'h0, 16'h0800, 16'h0200, 8'h00, 32'h0A640A64, 32'h0A640A64},
        '{2'h1, 16'h0800, 16'h0200, 8'h00, 32'h0A640A64, 32'h0ABE0ABE},
        '{2'h1, 16'h0800, 16'h0000, 8'h00, 32'h0A640A64, 32'h0A640A64},
        '{2'h1, 16'h0800, 16'hFF80, 8'h00, 32'h0A640A64, 32'h0A4D0A4D},
        '{2'h1, 16'h0800, 16'hFE00, 8'h00, 32'h0A640A64, 32'h0A370A37},
        '{2'h1, 16'h0800, 16'h1000, 8'h00, 32'h64C864C8, 32'h64FF64FF},
        '{2'h1, 16'h5A00, 16'h0200, 8'h00, 32'h64AA64AA, 32'h64F064F0},
        '{2'h1, 16'h3B00, 16'h0200, 8'h00, 32'h64A064A0, 32'h64DC64DC},
        '{2'h1, 16'h3C00, 16'h0200, 8'h00, 32'h64A064A0, 32'h64A064A0},
        '{2'h1, 16'hFFFF, 16'h0200, 8'h00, 32'h64A464A4, 32'h64A464A4},
        '{2'h3, 16'hFF00, 16'h0200, 8'h10, 32'h00320032, 32'h00640064},
        '{2'h3, 16'h0000, 16'h0200, 8'h10, 32'h00300030, 32'h00300030}};

    esf_filter i_dut (.clock(clock), .rst_n(rst_n), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_we(reg_we), .reg_re(reg_re), .reg_rdata(reg_rdata),
        .noise_level(noise_level), .pix_in(pix_in), .pix_out(pix_out));
    esf_pix_src i_src (.clock(clock), .pix(pix_in));

    initial begin
        clock = 1'b0;
        forever #25 clock = ~clock;
    end

    always @(posedge clock) if (pix_out.valid === 1'b1) outq.push_back(pix_out.data);

    // Reference kernel: left and upper neighbours, threshold, clamped amount.
    function automatic logic [7:0] kern(input esf_row_s r, input int p, input int l, input int u);
        int g;
        int t;
        int a;
        int c;
        g = (p > l) ? p - l : l - p;
        t = (p > u) ? p - u : u - p;
        g = (t > g) ? t : g;
        t = r.ctrl[1] ? (int'(r.noise) * int'(RST_AUTO_GAIN)) >> 4 : int'(r.thr) >> 8;
        t = (t > int'(THR_MAX_PIX)) ? int'(THR_MAX_PIX) : t;
        a = int'($signed(r.amt));
        a = (a > 2048) ? 2048 : (a < -256) ? -256 : a;
        c = p + (((p - ((l + u) >> 1)) * a) >>> 8);
        c = (c > 255) ? 255 : (c < 0) ? 0 : c;
        return (r.ctrl[0] && g > t) ? 8'(c) : 8'(p);
    endfunction : kern

    task automatic reg_wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge clock);
        reg_addr <= a;
        reg_wdata <= d;
        reg_we <= 1'b1;
        @(posedge clock);
        reg_we <= 1'b0;
    endtask : reg_wr

    task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp);
        @(posedge clock);
        reg_addr <= a;
        reg_re <= 1'b1;
        @(posedge clock);
        reg_re <= 1'b0;
        #1;
        `CHK("register", exp, reg_rdata)
    endtask : rd_chk

    task automatic end_of_test();
        $display("comparisons %0d mismatches %0d", cmp_count, n_errors);
        if (n_errors == 0 && cmp_count > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask : end_of_test

    initial begin
        repeat (5000) @(posedge clock);
        n_errors++;
        end_of_test();
    end

    initial begin
        esf_row_s   r;
        logic [7:0] e;
        static int  lx[4] = '{0, 0, 2, 2};
        static int  ux[4] = '{0, 1, 0, 1};
        rst_n = 1'b0;
        reg_addr = 8'h00;
        reg_wdata = 32'h00000000;
        reg_we = 1'b0;
        reg_re = 1'b0;
        noise_level = 8'h00;
        repeat (20) @(posedge clock);
        rst_n <= 1'b1;
        repeat (3) @(posedge clock);
        foreach (rows[i]) begin
            r = rows[i];
            reg_wr(OFS_CTRL, 32'(r.ctrl));
            reg_wr(OFS_THRESH, 32'(r.thr));
            reg_wr(OFS_AMOUNT, 32'(r.amt));
            noise_level <= r.noise;
            repeat (3) @(posedge clock);
            outq.delete();
            i_src.send(r.px[3], 1'b1, 1'b0);
            i_src.send(r.px[2], 1'b0, 1'b1);
            i_src.send(r.px[1], 1'b0, 1'b0);
            i_src.send(r.px[0], 1'b0, 1'b1);
            repeat (5) @(posedge clock);
            `CHK("count", 4, outq.size())
            for (int j = 0; j < 4; j++) begin
                e = kern(r, r.px[3-j], r.px[3-lx[j]], r.px[3-ux[j]]);
                `CHK("pixel", e, outq[j])
                `CHK("table", r.want[3-j], outq[j])
            end
            $display("row %0d done", i);
        end
        rd_chk(OFS_FRAME_CNT, 32'h0000000C);
        rd_chk(OFS_LINE_LEN, 32'h00000002);
        rd_chk(OFS_EDGE_CNT, 32'h00000002);
        rd_chk(OFS_NOISE, 32'h00000010);
        rd_chk(OFS_STATUS, 32'h00000002);
        rd_chk(OFS_THRESH, 32'h00000000);
        $display("status test done");
        rst_n <= 1'b0;
        repeat (3) @(posedge clock);
        rst_n <= 1'b1;
        repeat (3) @(posedge clock);
        rd_chk(OFS_CTRL, 32'h00000000);
        rd_chk(OFS_AMOUNT, 32'h00000200);
        rd_chk(OFS_ACT_THR, 32'h00000008);
        reg_wr(OFS_ACT_THR, 32'h0000003F);
        rd_chk(OFS_ACT_THR, 32'h00000008);
        rd_chk(8'h40, 32'h00000000);
        rd_chk(OFS_STATUS, 32'h00000001);
        rd_chk(OFS_FRAME_CNT, 32'h00000000);
        $display("reset test done");
        reg_wr(OFS_CTRL, 32'h00000002);
        reg_wr(OFS_AUTO_GAIN, 32'h00000010);
        noise_level <= 8'h30;
        rd_chk(OFS_ACT_THR, 32'h00000030);
        rd_chk(OFS_AUTO_GAIN, 32'h00000010);
        reg_wr(OFS_AUTO_GAIN, 32'h000000FF);
        noise_level <= 8'hFF;
        rd_chk(OFS_ACT_THR, 32'h00000040);
        reg_wr(OFS_CTRL, 32'h00000000);
        rd_chk(OFS_ACT_THR, 32'h00000008);
        $display("auto threshold test done");
        end_of_test();
    end
endmodule : tb_edge_sharpening_filter

bind esf_filter esf_filter_properties i_props (.clock(clock), .rst_n(rst_n),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_we(reg_we), .reg_re(reg_re),
    .reg_rdata(reg_rdata), .noise_level(noise_level), .pix_in(pix_in), .pix_out(pix_out));
